// File: pkg/pdr_pkg.sv
// Package for the PCI delayed-read and command-decode block.
// Assumes a single 40 MHz clock and a plain register port.
package pdr_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_DTE_OFF = 8'hF4;
   localparam logic [7:0] REG_DTT_OFF = 8'hF6;
   localparam logic [7:0] REG_STATUS_OFF = 8'hF8;
   localparam logic [7:0] REG_DECODE_OFF = 8'hFA;
   localparam logic [7:0] REG_DTE_RST = 8'h01;
   localparam logic [7:0] REG_DTT_RST = 8'h01;
   localparam logic [7:0] REG_DECODE_RST = 8'h00;
   localparam int EN_BIT = 0;
   localparam int SUBTR_BIT = 0;
   localparam int FIRST_PHASE_CLKS = 32;
   localparam int DISCARD_CLKS = 1024;
   localparam int CACHE_LINE_BYTES = 32;
   localparam int WATCH_LINES = 2;
   localparam logic [7:0] CFG_BUS = 8'h00;
   localparam logic [4:0] CFG_DEV = 5'h07;
   localparam logic [3:0] CMD_INTA = 4'h0;
   localparam logic [3:0] CMD_SPECIAL = 4'h1;
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
   localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
   localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;
   localparam logic [1:0] TGT_NONE = 2'h0;
   localparam logic [1:0] TGT_IO = 2'h1;
   localparam logic [1:0] TGT_MEM = 2'h2;
   localparam logic [1:0] TGT_CFG = 2'h3;
   typedef enum logic [2:0] {
      PDR_IDLE, PDR_WAIT, PDR_CONN, PDR_FETCH, PDR_VALID
   } pdr_state_e;
endpackage

// File: verilog/pdr_cmd_decode.sv
// Peripheral-cluster PCI command decode, target and initiator sides.
// Assumes the command, address and hit inputs are stable during the address phase.
`timescale 1ns/1ps
`default_nettype none
module pdr_cmd_decode (
   input wire logic [3:0] cmd_in,
   input wire logic [31:0] addr_in,
   input wire logic cfg_bus0_in,
   input wire logic io_hit_in,
   input wire logic mem_hit_in,
   input wire logic subtractive_in,
   input wire logic addr_phase_in,
   output logic claim_out,
   output logic [1:0] target_class_out,
   output logic is_read_out,
   output logic init_cmd_ok_out
);
   logic mem_rd, mem_wr, io_cmd, cfg_cmd, ack_cmd, cfg_dev7, pos_hit;
   assign mem_rd = (cmd_in == pdr_pkg::CMD_MEM_RD) || (cmd_in == pdr_pkg::CMD_MEM_RD_MULT)
                   || (cmd_in == pdr_pkg::CMD_MEM_RD_LINE);
   assign mem_wr = (cmd_in == pdr_pkg::CMD_MEM_WR) || (cmd_in == pdr_pkg::CMD_MEM_WR_INV);
   assign io_cmd = (cmd_in == pdr_pkg::CMD_IO_RD) || (cmd_in == pdr_pkg::CMD_IO_WR);
   assign cfg_cmd = (cmd_in == pdr_pkg::CMD_CFG_RD) || (cmd_in == pdr_pkg::CMD_CFG_WR);
   assign ack_cmd = (cmd_in == pdr_pkg::CMD_INTA) || (cmd_in == pdr_pkg::CMD_SPECIAL);
   // Type 0 addresses keep the low two bits clear; device number comes from the upper address
   assign cfg_dev7 = cfg_bus0_in && (addr_in[1:0] == 2'h0) && (addr_in[15:11] == pdr_pkg::CFG_DEV);
   assign pos_hit = ack_cmd || (io_cmd && io_hit_in) || ((mem_rd || mem_wr) && mem_hit_in)
                    || (cfg_cmd && cfg_dev7);
   // Subtractive mode takes every memory or I/O cycle nobody else claimed
   assign claim_out = addr_phase_in && (pos_hit || (subtractive_in && (io_cmd || mem_rd || mem_wr)));
   assign target_class_out = (mem_rd || mem_wr) ? pdr_pkg::TGT_MEM :
                             io_cmd ? pdr_pkg::TGT_IO :
                             cfg_cmd ? pdr_pkg::TGT_CFG : pdr_pkg::TGT_NONE;
   assign is_read_out = mem_rd || (cmd_in == pdr_pkg::CMD_IO_RD) || (cmd_in == pdr_pkg::CMD_CFG_RD);
   assign init_cmd_ok_out = io_cmd || (cmd_in == pdr_pkg::CMD_MEM_RD) || (cmd_in == pdr_pkg::CMD_MEM_WR);
endmodule
`default_nettype wire

// File: verilog/pdr_bridge.sv
// Delayed-read engine for PCI-to-DRAM reads plus peripheral command decode.
// Assumes the DRAM fetch side signals data ready and that all inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Delayed termination only for DRAM reads
// - Retry master, keep fetching in background
// - Delay if over 32 clocks or outbound queued
// - Either control off: hold in wait states
// - Queued processor write converts connected read
// - Buffer data; order later writes behind it
// - Drop data after 1024 clocks without repeat
// - Match repeat by address, ignore byte enables
// - Write within two lines discards data
// - Locked processor cycle during fetch discards
// - Claim positively or subtractively by mode
// - Accept interrupt acknowledge and special cycles
// - Accept I/O reads and writes
// - Memory commands only for USB, expansion
// - Claim type 0 config to device 7
// - Read multiple and read line alias read
// - Write and invalidate aliases write
// - Initiator issues memory and I/O only
// - Initiate only after arbiter grant
module pdr_bridge #(
   parameter int DISCARD_CYCLES = pdr_pkg::DISCARD_CLKS,
   parameter int FIRST_CYCLES = pdr_pkg::FIRST_PHASE_CLKS,
   parameter int DATA_W = 32
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic rd_req_in,
   input wire logic [3:0] rd_cmd_in,
   input wire logic [31:0] rd_addr_in,
   input wire logic rd_dram_hit_in,
   output logic rd_retry_out,
   output logic rd_wait_out,
   output logic rd_done_out,
   output logic [DATA_W-1:0] rd_data_out,
   output logic fetch_req_out,
   output logic [31:0] fetch_addr_out,
   input wire logic fetch_valid_in,
   input wire logic [DATA_W-1:0] fetch_data_in,
   input wire logic out_queued_in,
   input wire logic cpu_wr_queued_in,
   output logic cpu_wr_hold_out,
   input wire logic cpu_lock_queued_in,
   input wire logic pci_wr_in,
   input wire logic [31:0] pci_wr_addr_in,
   input wire logic [3:0] tgt_cmd_in,
   input wire logic [31:0] tgt_addr_in,
   input wire logic tgt_addr_phase_in,
   input wire logic tgt_cfg_bus0_in,
   input wire logic tgt_io_hit_in,
   input wire logic tgt_mem_hit_in,
   output logic tgt_claim_out,
   output logic [1:0] tgt_class_out,
   output logic tgt_read_out,
   input wire logic init_req_in,
   input wire logic [3:0] init_cmd_in,
   input wire logic init_gnt_in,
   output logic init_start_out,
   output logic init_reject_out
);
   localparam int DCW = $clog2(DISCARD_CYCLES + 1);
   localparam int FCW = $clog2(FIRST_CYCLES + 1);
   localparam logic [31:0] WATCH_SPAN = 32'(pdr_pkg::CACHE_LINE_BYTES * pdr_pkg::WATCH_LINES);

   pdr_pkg::pdr_state_e state_q, state_d;
   logic [7:0] dte_q, dtt_q, decode_q, rdata_q;
   logic [31:0] daddr_q;
   logic [DATA_W-1:0] dbuf_q, rdata_bus_q;
   logic [DCW-1:0] disc_cnt_q;
   logic [FCW-1:0] wait_cnt_q;
   logic retry_q, done_q, init_start_q, init_rej_q;

   // Address window helper used for the snoop window only; the repeat needs an exact address match
   function automatic logic in_window(input logic [31:0] base, input logic [31:0] a);
      logic [31:0] off;
      off = a - base;
      return (a >= base) && (off < WATCH_SPAN);
   endfunction

   logic dram_rd, dt_enabled, is_repeat, over_time, sneak, discard_win, discard_lock, disc_expired;
   logic wr_dte, wr_dtt, wr_dec, start_new;
   // Only memory reads of the aliased kinds to DRAM may be delayed
   assign dram_rd = rd_req_in && rd_dram_hit_in && ((rd_cmd_in == pdr_pkg::CMD_MEM_RD)
                    || (rd_cmd_in == pdr_pkg::CMD_MEM_RD_LINE) || (rd_cmd_in == pdr_pkg::CMD_MEM_RD_MULT));
   assign dt_enabled = dte_q[pdr_pkg::EN_BIT] && dtt_q[pdr_pkg::EN_BIT];
   assign is_repeat = dram_rd && (rd_addr_in == daddr_q);
   assign over_time = (wait_cnt_q >= FCW'(FIRST_CYCLES));
   assign sneak = cpu_wr_queued_in;
   assign discard_win = pci_wr_in && in_window(daddr_q, pci_wr_addr_in);
   assign discard_lock = (state_q == pdr_pkg::PDR_FETCH) && cpu_lock_queued_in;
   assign disc_expired = (disc_cnt_q == DCW'(DISCARD_CYCLES));
   assign wr_dte = reg_wr_in && (reg_addr_in == pdr_pkg::REG_DTE_OFF);
   assign wr_dtt = reg_wr_in && (reg_addr_in == pdr_pkg::REG_DTT_OFF);
   assign wr_dec = reg_wr_in && (reg_addr_in == pdr_pkg::REG_DECODE_OFF);
   assign start_new = dram_rd && (state_q == pdr_pkg::PDR_IDLE);

   always_comb begin
      state_d = state_q;
      case (state_q)
         pdr_pkg::PDR_IDLE: begin
            if (start_new) begin
               if (!dt_enabled) begin
                  state_d = pdr_pkg::PDR_WAIT;
               end else if (out_queued_in) begin
                  state_d = pdr_pkg::PDR_FETCH;
               end else begin
                  state_d = pdr_pkg::PDR_CONN;
               end
            end
         end
         pdr_pkg::PDR_WAIT: begin
            if (fetch_valid_in) begin
               state_d = pdr_pkg::PDR_IDLE;
            end
         end
         pdr_pkg::PDR_CONN: begin
            if (fetch_valid_in) begin
               state_d = pdr_pkg::PDR_IDLE;
            end else if (over_time || sneak || out_queued_in) begin
               state_d = pdr_pkg::PDR_FETCH;
            end
         end
         pdr_pkg::PDR_FETCH: begin
            if (discard_lock || discard_win) begin
               state_d = pdr_pkg::PDR_IDLE;
            end else if (fetch_valid_in) begin
               state_d = pdr_pkg::PDR_VALID;
            end
         end
         pdr_pkg::PDR_VALID: begin
            // Reads to any other address get no answer until the buffer is freed
            if (is_repeat || disc_expired || discard_win) begin
               state_d = pdr_pkg::PDR_IDLE;
            end
         end
         default: state_d = pdr_pkg::PDR_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         state_q <= pdr_pkg::PDR_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         daddr_q <= '0;
      end else if (start_new) begin
         daddr_q <= rd_addr_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         dbuf_q <= '0;
      end else if (fetch_valid_in && (state_q == pdr_pkg::PDR_FETCH)) begin
         dbuf_q <= fetch_data_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || state_q != pdr_pkg::PDR_CONN) begin
         wait_cnt_q <= '0;
      end else if (!over_time) begin
         wait_cnt_q <= wait_cnt_q + FCW'(1);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || state_q != pdr_pkg::PDR_VALID) begin
         disc_cnt_q <= '0;
      end else if (!disc_expired) begin
         disc_cnt_q <= disc_cnt_q + DCW'(1);
      end
   end

   // Retry answers a new read sent straight to fetch, a connected read that converts, or any DRAM read during the fetch
   logic retry_d, done_d;
   logic [DATA_W-1:0] rdata_bus_d;
   assign retry_d = (start_new && dt_enabled && out_queued_in)
                    || ((state_q == pdr_pkg::PDR_CONN) && state_d == pdr_pkg::PDR_FETCH)
                    || ((state_q == pdr_pkg::PDR_FETCH) && dram_rd);
   assign done_d = ((state_q == pdr_pkg::PDR_VALID) && is_repeat)
                   || (((state_q == pdr_pkg::PDR_WAIT) || (state_q == pdr_pkg::PDR_CONN)) && fetch_valid_in);
   assign rdata_bus_d = (state_q == pdr_pkg::PDR_VALID) ? dbuf_q : fetch_data_in;

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         retry_q <= 1'b0;
         done_q <= 1'b0;
         rdata_bus_q <= '0;
      end else begin
         retry_q <= retry_d;
         done_q <= done_d;
         if (done_d) begin
            rdata_bus_q <= rdata_bus_d;
         end
      end
   end

   assign rd_retry_out = retry_q;
   assign rd_done_out = done_q;
   assign rd_data_out = rdata_bus_q;
   assign rd_wait_out = (state_q == pdr_pkg::PDR_WAIT) || (state_q == pdr_pkg::PDR_CONN);
   assign fetch_req_out = (state_q == pdr_pkg::PDR_WAIT) || (state_q == pdr_pkg::PDR_CONN)
                          || (state_q == pdr_pkg::PDR_FETCH);
   assign fetch_addr_out = daddr_q;
   // Holding processor writes while a delayed read is pending prevents starvation
   assign cpu_wr_hold_out = (state_q == pdr_pkg::PDR_FETCH) || (state_q == pdr_pkg::PDR_VALID);

   // Register port
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         dte_q <= pdr_pkg::REG_DTE_RST;
         dtt_q <= pdr_pkg::REG_DTT_RST;
         decode_q <= pdr_pkg::REG_DECODE_RST;
      end else begin
         if (wr_dte) begin
            dte_q <= reg_wdata_in;
         end
         if (wr_dtt) begin
            dtt_q <= reg_wdata_in;
         end
         if (wr_dec) begin
            decode_q <= reg_wdata_in;
         end
      end
   end

   logic [7:0] rd_mux;
   assign rd_mux = (reg_addr_in == pdr_pkg::REG_DTE_OFF) ? dte_q :
                   (reg_addr_in == pdr_pkg::REG_DTT_OFF) ? dtt_q :
                   (reg_addr_in == pdr_pkg::REG_DECODE_OFF) ? decode_q :
                   (reg_addr_in == pdr_pkg::REG_STATUS_OFF) ? {5'h00, state_q} : 8'h00;

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_in) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign reg_rdata_out = rdata_q;

   // Target decode for the peripheral cluster
   logic init_ok;
   pdr_cmd_decode u_decode (
      .cmd_in(tgt_cmd_in),
      .addr_in(tgt_addr_in),
      .cfg_bus0_in(tgt_cfg_bus0_in),
      .io_hit_in(tgt_io_hit_in),
      .mem_hit_in(tgt_mem_hit_in),
      .subtractive_in(decode_q[pdr_pkg::SUBTR_BIT]),
      .addr_phase_in(tgt_addr_phase_in),
      .claim_out(tgt_claim_out),
      .target_class_out(tgt_class_out),
      .is_read_out(tgt_read_out),
      .init_cmd_ok_out()
   );

   // Second decoder checks the initiator command
   pdr_cmd_decode u_init_decode (
      .cmd_in(init_cmd_in),
      .addr_in(32'h0000_0000),
      .cfg_bus0_in(1'b0),
      .io_hit_in(1'b0),
      .mem_hit_in(1'b0),
      .subtractive_in(1'b0),
      .addr_phase_in(1'b0),
      .claim_out(),
      .target_class_out(),
      .is_read_out(),
      .init_cmd_ok_out(init_ok)
   );

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         init_start_q <= 1'b0;
         init_rej_q <= 1'b0;
      end else begin
         init_start_q <= init_req_in && init_gnt_in && init_ok;
         init_rej_q <= init_req_in && !init_ok;
      end
   end
   assign init_start_out = init_start_q;
   assign init_reject_out = init_rej_q;
endmodule
`default_nettype wire

// File: test/pdr_props.sv
// Port-level assertions for the delayed-read bridge and command decode.
// Bound into pdr_bridge from the testbench top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pdr_props (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic rd_retry_out,
   input wire logic rd_done_out,
   input wire logic cpu_wr_hold_out,
   input wire logic [3:0] tgt_cmd_in,
   input wire logic [31:0] tgt_addr_in,
   input wire logic tgt_addr_phase_in,
   input wire logic tgt_cfg_bus0_in,
   input wire logic tgt_io_hit_in,
   input wire logic tgt_mem_hit_in,
   input wire logic tgt_claim_out,
   input wire logic [1:0] tgt_class_out,
   input wire logic tgt_read_out,
   input wire logic init_req_in,
   input wire logic [3:0] init_cmd_in,
   input wire logic init_gnt_in,
   input wire logic init_start_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   wire logic ph = tgt_addr_phase_in;
   wire logic cfg7 = tgt_cfg_bus0_in && tgt_addr_in[15:11] == 5'h07 && tgt_addr_in[1:0] == 2'h0;
   property p_retry_nodata; rd_retry_out |-> !rd_done_out; endproperty
   a_retry_nodata: assert property (p_retry_nodata) else $error("retry with data");
   property p_retry_hold; rd_retry_out |-> cpu_wr_hold_out; endproperty
   a_retry_hold: assert property (p_retry_hold) else $error("writes not held behind read");
   property p_io; ph && tgt_io_hit_in && tgt_cmd_in[3:1] == 3'h1 |-> tgt_claim_out && tgt_class_out == 2'h1; endproperty
   a_io: assert property (p_io) else $error("io command not claimed");
   property p_cfg; ph && cfg7 && tgt_cmd_in[3:1] == 3'h5 |-> tgt_claim_out && tgt_class_out == 2'h3; endproperty
   a_cfg: assert property (p_cfg) else $error("config cycle not claimed");
   property p_rd_alias; ph && tgt_mem_hit_in && tgt_cmd_in inside {4'hC, 4'hE} |-> tgt_class_out == 2'h2 && tgt_read_out; endproperty
   a_rd_alias: assert property (p_rd_alias) else $error("read alias decoded wrong");
   property p_wr_alias; ph && tgt_mem_hit_in && tgt_cmd_in == 4'hF |-> tgt_class_out == 2'h2 && !tgt_read_out; endproperty
   a_wr_alias: assert property (p_wr_alias) else $error("write alias decoded wrong");
   property p_init_cmd; init_start_out |-> $past(init_cmd_in[1] && !init_cmd_in[3]); endproperty
   a_init_cmd: assert property (p_init_cmd) else $error("illegal initiator command");
   property p_init_go; init_req_in && init_gnt_in && init_cmd_in[1] && !init_cmd_in[3] |=> init_start_out; endproperty
   a_init_go: assert property (p_init_go) else $error("granted cycle not started");
   property p_init_gnt; init_start_out |-> $past(init_gnt_in && init_req_in); endproperty
   a_init_gnt: assert property (p_init_gnt) else $error("start without grant");
   c_retry: cover property (rd_retry_out);
   c_done: cover property (rd_done_out);
   c_start: cover property (init_start_out);
endmodule
`default_nettype wire

// File: test/pdr_dram_model.sv
// DRAM fetch responder and bus arbiter facing the bridge.
// Latency and grant denial are set by the testbench.
`timescale 1ns/1ps
`default_nettype none
module pdr_dram_model (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic fetch_req_out,
   input wire logic [31:0] fetch_addr_out,
   input wire logic [7:0] lat_in,
   input wire logic init_req_in,
   input wire logic deny_in,
   output logic fetch_valid_in,
   output logic [31:0] fetch_data_in,
   output logic init_gnt_in
);
   logic [7:0] cnt_q;
   logic sent_q;
   always_ff @(posedge ref_clk_in) begin
      fetch_valid_in <= 1'b0;
      // Data lines do not hold their value outside the valid cycle
      fetch_data_in <= ~fetch_data_in;
      init_gnt_in <= init_req_in && !deny_in;
      if (sys_rst_in || !fetch_req_out) begin
         cnt_q <= 8'h00;
         sent_q <= 1'b0;
         if (sys_rst_in) fetch_data_in <= 32'h0;
      end else if (!sent_q && cnt_q == lat_in) begin
         fetch_valid_in <= 1'b1;
         fetch_data_in <= fetch_addr_out ^ 32'hC3C30F0F;
         sent_q <= 1'b1;
      end else cnt_q <= cnt_q + 8'h01;
   end
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for pdr_bridge with short timer parameters.
// Drives the register port, PCI master reads, target and initiator decode.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic ref_clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, rd_req_in = 0, rd_dram_hit_in = 1;
   logic out_queued_in = 0, cpu_wr_queued_in = 0, cpu_lock_queued_in = 0, pci_wr_in = 0, deny_in = 0;
   logic tgt_addr_phase_in = 0, tgt_cfg_bus0_in = 0, tgt_io_hit_in = 0, tgt_mem_hit_in = 0, init_req_in = 0;
   logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, lat_in = 0, reg_rdata_out;
   logic [3:0] rd_cmd_in = 0, tgt_cmd_in = 0, init_cmd_in = 0;
   logic [31:0] rd_addr_in = 0, pci_wr_addr_in = 0, tgt_addr_in = 0, rd_data_out, fetch_addr_out, fetch_data_in;
   logic rd_retry_out, rd_wait_out, rd_done_out, fetch_req_out, fetch_valid_in, cpu_wr_hold_out;
   logic tgt_claim_out, tgt_read_out, init_gnt_in, init_start_out, init_reject_out;
   logic [1:0] tgt_class_out;
   int errors = 0, checks_done = 0, cyc = 0, n_rt = 0, n_dn = 0, n_wt = 0;
   pdr_bridge #(.DISCARD_CYCLES(16), .FIRST_CYCLES(4)) u_pdr_bridge (.*);
   pdr_dram_model u_pdr_dram_model (.*);
   always #12.5 ref_clk_in = ~ref_clk_in;
   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   // Master releases its request once retried or once data arrives
   always @(posedge ref_clk_in) begin
      cyc++;
      if (rd_retry_out === 1'b1) n_rt++;
      if (rd_done_out === 1'b1) n_dn++;
      if (rd_wait_out === 1'b1) n_wt++;
      if (rd_req_in && (rd_retry_out || fetch_valid_in)) rd_req_in <= 1'b0;
      if (cyc > 20000) begin
         errors++;
         stop_test;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1 chk("reg", e, reg_rdata_out);
   endtask
   task automatic pw(input logic [31:0] a);
      @(posedge ref_clk_in);
      pci_wr_addr_in <= a;
      pci_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      pci_wr_in <= 1'b0;
   endtask
   // A repeat into buffered data or a memory write is a one-cycle request; other reads hold until answered
   task automatic pci(input logic [3:0] c, input logic [31:0] a, input bit hold);
      @(posedge ref_clk_in);
      rd_cmd_in <= c;
      rd_addr_in <= a;
      rd_req_in <= 1'b1;
      @(posedge ref_clk_in);
      if (!hold) rd_req_in <= 1'b0;
      for (int i = 0; i < 300 && rd_req_in; i++) @(posedge ref_clk_in);
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask
   initial begin
      int r0, d0, w0;
      repeat (4) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rd(8'hF4, 8'h01);
      rd(8'hF6, 8'h01);
      rd(8'hFA, 8'h00);
      wr(8'h10, 8'h5A);
      rd(8'h10, 8'h00);
      for (int k = 0; k < 2; k++) begin
         r0 = n_rt;
         d0 = n_dn;
         w0 = n_wt;
         lat_in <= 8'd12;
         wr(k ? 8'hF6 : 8'hF4, 8'h00);
         rd(k ? 8'hF6 : 8'hF4, 8'h00);
         pci(4'h6, 32'h1000 + k * 64, 1);
         chk("retry", r0, n_rt);
         chk("wait", 1, n_wt > w0);
         chk("done", d0 + 1, n_dn);
         chk("data", (32'h1000 + k * 64) ^ 32'hC3C30F0F, rd_data_out);
         wr(k ? 8'hF6 : 8'hF4, 8'h01);
      end
      r0 = n_rt;
      out_queued_in <= 1'b1;
      pci(4'h7, 32'h1800, 0);
      chk("retry", r0, n_rt);
      d0 = n_dn;
      lat_in <= 8'd0;
      pci(4'h6, 32'h2000, 1);
      out_queued_in <= 1'b0;
      chk("retry", 1, n_rt > r0);
      chk("done", d0, n_dn);
      rd(8'hF8, 8'h04);
      chk("hold", 1, cpu_wr_hold_out);
      pci(4'hE, 32'h2000, 0);
      chk("done", d0 + 1, n_dn);
      chk("data", 32'h2000 ^ 32'hC3C30F0F, rd_data_out);
      rd(8'hF8, 8'h00);
      r0 = n_rt;
      lat_in <= 8'd20;
      pci(4'hC, 32'h3000, 1);
      chk("retry", 1, n_rt > r0);
      repeat (60) @(posedge ref_clk_in);
      rd(8'hF8, 8'h00);
      lat_in <= 8'd0;
      out_queued_in <= 1'b1;
      pci(4'h6, 32'h4000, 1);
      out_queued_in <= 1'b0;
      pw(32'h4040);
      rd(8'hF8, 8'h04);
      pw(32'h403C);
      rd(8'hF8, 8'h00);
      lat_in <= 8'd30;
      out_queued_in <= 1'b1;
      pci(4'h6, 32'h5000, 1);
      out_queued_in <= 1'b0;
      cpu_lock_queued_in <= 1'b1;
      rd(8'hF8, 8'h00);
      cpu_lock_queued_in <= 1'b0;
      r0 = n_rt;
      d0 = n_dn;
      lat_in <= 8'd2;
      cpu_wr_queued_in <= 1'b1;
      pci(4'h6, 32'h6000, 1);
      cpu_wr_queued_in <= 1'b0;
      chk("retry", 1, n_rt > r0);
      chk("done", d0, n_dn);
      repeat (60) @(posedge ref_clk_in);
      // Fast fetch with nothing queued stays connected and completes in wait states
      r0 = n_rt;
      d0 = n_dn;
      lat_in <= 8'd1;
      pci(4'h6, 32'h7000, 1);
      chk("retry", r0, n_rt);
      chk("done", d0 + 1, n_dn);
      chk("data", 32'h7000 ^ 32'hC3C30F0F, rd_data_out);
      tgt_addr_in <= 32'h3800;
      tgt_addr_phase_in <= 1'b1;
      tgt_cfg_bus0_in <= 1'b1;
      tgt_io_hit_in <= 1'b1;
      tgt_mem_hit_in <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         tgt_cmd_in <= c[3:0];
         @(posedge ref_clk_in);
         #1 chk("claim", !(c inside {4, 5, 8, 9, 13}), tgt_claim_out);
      end
      tgt_cmd_in <= 4'h7;
      tgt_mem_hit_in <= 1'b0;
      #25 chk("claim", 0, tgt_claim_out);
      wr(8'hFA, 8'h01);
      #1 chk("claim", 1, tgt_claim_out);
      wr(8'hFA, 8'h00);
      tgt_addr_in <= 32'h3000;
      tgt_cmd_in <= 4'hA;
      #25 chk("claim", 0, tgt_claim_out);
      init_req_in <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         init_cmd_in <= c[3:0];
         repeat (2) @(posedge ref_clk_in);
         #1 chk("start", c inside {2, 3, 6, 7}, init_start_out);
         chk("reject", !(c inside {2, 3, 6, 7}), init_reject_out);
      end
      // A legal command, so only the missing grant can keep the start low
      init_cmd_in <= 4'h6;
      deny_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      #1 chk("start", 0, init_start_out);
      stop_test;
   end
endmodule
bind pdr_bridge pdr_props u_pdr_props (.*);
`default_nettype wire
